// [common/wwd_consts.svh]
// Purpose: Named constants for the window watchdog and fail-safe supervisor
// Assumes: 20 MHz core clock; times in ns, windows in oscillator ticks
// Notes: Counts derived from these times are computed inside the modules
`ifndef WWD_CONSTS_SVH
`define WWD_CONSTS_SVH
`define WWD_CLK_NS 50
`define WWD_TRIG_MIN_NS 7000
`define WWD_RST_NS 4000000
`define WWD_IGN_DEB_NS 100000
`define WWD_LEAD_TICKS 7895
`define WWD_CLOSED_TICKS 1053
`define WWD_OPEN_TICKS 1105
`define WWD_FS_SHORT_TICKS 2000
`define WWD_FS_OPEN_TICKS 3000
`define WWD_INT_OSC_DIV 392
`define WWD_SYNC_W 11
// Idle pin levels after reset: trigger, select, transmit and bus sit high; strap, ignition and timing pin sit low
`define WWD_SYNC_IDLE 11'h590
`endif

// [common/wwd_pkg.sv]
// Purpose: Types shared by the watchdog supervisor
// Assumes: Nothing beyond the constants header
// Notes: State codes 6 and 7 are illegal
package wwd_pkg;
    typedef enum logic [2:0] {
        WWD_ST_RESET = 3'h0,
        WWD_ST_LEAD = 3'h1,
        WWD_ST_CLOSED = 3'h2,
        WWD_ST_OPEN = 3'h3,
        WWD_ST_FAILSAFE = 3'h4,
        WWD_ST_OFF = 3'h5
    } wwd_state_t;

    // Analog fault detector levels, all asynchronous to core_clk
    typedef struct packed {
        logic osc_short;
        logic osc_open;
        logic vcc_uv;
        logic vcc_ot;
        logic lin_ot;
        logic lin_short;
    } wwd_fault_t;
endpackage

// [core/wwd_supervisor.sv]
// Purpose: Window watchdog with oscillator fail-safe, ignition wake, LIN and VCC faults
// Assumes: Pins and analog flags are asynchronous; config strobe is on core_clk
// Notes: Functional notes below; hysteresis lives in the analog comparators
// Functional notes
// RULE1: Windows come from oscillator ticks, so they inherit its 20% tolerance.
// RULE2: Host triggers between longest closed and shortest closed plus open.
// RULE3: Bad timing resistor gives endless watchdog resets unless disabled.
// RULE4: Timing pin short or open switches ticks to internal oscillator.
// RULE5: Shorted pin resets after short delay, open pin after open delay.
// RULE6: Disable bit sets only after two consecutive writes of one.
// RULE7: Ignition low is passive; high gives interrupt awake or wake asleep.
// RULE8: Ignition debounce completion pulls interrupt output low.
// RULE9: LIN driver returns after overtemperature only when transmit is zero.
// RULE10: Receive output tracks the LIN bus during thermal shutdown.
// RULE11: Sleep allowed with LIN shorted; short removal wakes remotely.
// RULE12: VCC undervoltage resets; VCC overtemperature switches regulator off.
// RULE13: Regulator thermal supervision is independent of LIN thermal state.
// RULE14: Unconnected chip select reads deselected; serial output tri-stated.
// RULE15: Unconnected transmit reads high; transceiver stays recessive.
// RULE16: Trigger in closed window or missed open window drives reset low.
// RULE17: No first trigger within lead time gives a 4 ms reset.
// RULE18: Only triggers low longer than 7 us count; each restarts windows.
// RULE19: Lead, closed and open times are counts of oscillator ticks.
`timescale 1ns/1ps
`default_nettype none
`include "wwd_consts.svh"
module wwd_supervisor #(
    parameter int RST_CYC = `WWD_RST_NS / `WWD_CLK_NS,
    parameter int LEAD_TICKS = `WWD_LEAD_TICKS,
    parameter int CLOSED_TICKS = `WWD_CLOSED_TICKS,
    parameter int OPEN_TICKS = `WWD_OPEN_TICKS,
    parameter int FS_SHORT_TICKS = `WWD_FS_SHORT_TICKS,
    parameter int FS_OPEN_TICKS = `WWD_FS_OPEN_TICKS,
    parameter int INT_OSC_DIV = `WWD_INT_OSC_DIV,
    parameter int DEB_CYC = `WWD_IGN_DEB_NS / `WWD_CLK_NS
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Host pins
    input wire logic wd_trigger_n,
    input wire logic divider_strap_pin,
    input wire logic spi_select_n,
    input wire logic txd_in,
    input wire logic ignition_input,
    output logic wd_reset_n,
    output logic irq_out_n,
    output logic rxd_out,
    output logic spi_miso_out,
    output logic spi_miso_oe,
    // Analog side
    input wire logic wd_timing_pin,
    input wire wwd_pkg::wwd_fault_t faults,
    input wire logic lin_bus_level,
    output logic lin_drv_dominant,
    output logic vcc_enable,
    // Core side, same clock
    input wire logic cfg_wr,
    input wire logic cfg_wd_disable_bit,
    input wire logic irq_clr,
    input wire logic sleep_mode,
    input wire logic spi_miso_data,
    output logic wake_req,
    output wwd_pkg::wwd_state_t wd_state,
    output logic wd_disabled
);
    import wwd_pkg::*;

    localparam int TRIG_CYC = (`WWD_TRIG_MIN_NS + `WWD_CLK_NS - 1) / `WWD_CLK_NS;

    logic [`WWD_SYNC_W-1:0] sync_q;
    wwd_fault_t f_s;
    logic trig_n_s, strap_s, sel_n_s, txd_s, ign_s, osc_s, bus_s;

    // Every pin level passes two flops first
    wwd_sync #(.W(`WWD_SYNC_W), .RST_VAL(`WWD_SYNC_IDLE)) u_sync (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .async_in({wd_trigger_n, divider_strap_pin, spi_select_n, txd_in, ignition_input,
                   wd_timing_pin, lin_bus_level, faults[3:0]}),
        .sync_out(sync_q)
    );
    assign {trig_n_s, strap_s, sel_n_s, txd_s, ign_s, osc_s, bus_s} = sync_q[10:4];

    // Timing pin faults need their own stages; the rest of the struct is above
    logic [1:0] ofm_reg, ofs_reg;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ofm_reg <= 2'h0;
            ofs_reg <= 2'h0;
        end else begin
            ofm_reg <= faults[5:4];
            ofs_reg <= ofm_reg;
        end
    end

    // Timing pin faults join the struct only after their own two stages
    assign f_s = {ofs_reg, sync_q[3:0]};

    wwd_state_t st_reg, st_next;
    logic [16:0] cyc_reg, cyc_next;
    logic [12:0] tcnt_reg, tcnt_next;
    logic [8:0] div_reg, div_next;
    logic [7:0] tlo_reg, tlo_next;
    logic osc_d_reg, por_reg, por_next, strap_dis_reg, strap_dis_next;
    logic cfg_dis_reg, cfg_dis_next, pend_reg, pend_next;
    logic wd_tick, int_tick, trig_acc, osc_fault, wd_off;

    assign osc_fault = |ofs_reg;
    assign int_tick = (div_reg == 9'(INT_OSC_DIV - 1));
    // RULE19 windows counted in ticks
    // RULE1 tolerance follows oscillator
    // RULE4 internal fallback
    assign wd_tick = osc_fault ? int_tick : (osc_s & ~osc_d_reg);
    assign wd_off = strap_dis_reg | cfg_dis_reg | sleep_mode;
    // RULE18 glitch filter: accept on the first low cycle beyond the minimum
    assign trig_acc = ~trig_n_s & (tlo_reg == 8'(TRIG_CYC));

    // Trigger filter, divider and disable bookkeeping
    always_comb begin
        tlo_next = trig_n_s ? 8'h00 : (tlo_reg > 8'(TRIG_CYC) ? tlo_reg : tlo_reg + 8'h01);
        div_next = int_tick ? 9'h000 : div_reg + 9'h001;
        pend_next = pend_reg;
        cfg_dis_next = cfg_dis_reg;
        // RULE6 two consecutive writes of one needed, a zero clears at once
        if (cfg_wr) begin
            pend_next = cfg_wd_disable_bit;
            cfg_dis_next = cfg_wd_disable_bit & (pend_reg | cfg_dis_reg);
        end
    end

    // Watchdog sequence
    always_comb begin
        st_next = st_reg;
        cyc_next = cyc_reg;
        tcnt_next = wd_tick ? tcnt_reg + 13'h0001 : tcnt_reg;
        por_next = por_reg | sleep_mode;
        strap_dis_next = strap_dis_reg;
        unique case (st_reg)
            WWD_ST_RESET: begin
                tcnt_next = 13'h0000;
                cyc_next = cyc_reg + 17'h00001;
                if (cyc_reg == 17'(RST_CYC - 1)) begin
                    cyc_next = 17'h00000;
                    st_next = WWD_ST_LEAD;
                    if (por_reg) begin
                        strap_dis_next = strap_s;
                    end
                    por_next = 1'b0;
                end
            end
            // RULE17 first trigger inside the lead time
            WWD_ST_LEAD: begin
                if (trig_acc) begin
                    st_next = WWD_ST_CLOSED;
                    tcnt_next = 13'h0000;
                end else if (wd_tick && tcnt_reg == 13'(LEAD_TICKS - 1)) begin
                    st_next = WWD_ST_RESET;
                end
            end
            // RULE16 early trigger resets at once
            WWD_ST_CLOSED: begin
                if (trig_acc) begin
                    st_next = WWD_ST_RESET;
                end else if (wd_tick && tcnt_reg == 13'(CLOSED_TICKS - 1)) begin
                    st_next = WWD_ST_OPEN;
                    tcnt_next = 13'h0000;
                end
            end
            // RULE16 missing the open window resets
            WWD_ST_OPEN: begin
                if (trig_acc) begin
                    st_next = WWD_ST_CLOSED;
                    tcnt_next = 13'h0000;
                end else if (wd_tick && tcnt_reg == 13'(OPEN_TICKS - 1)) begin
                    st_next = WWD_ST_RESET;
                end
            end
            // RULE5 delay depends on the kind of pin fault
            WWD_ST_FAILSAFE: begin
                if (wd_tick && tcnt_reg == (ofs_reg[1] ? 13'(FS_SHORT_TICKS - 1) :
                                            13'(FS_OPEN_TICKS - 1))) begin
                    st_next = WWD_ST_RESET;
                end
            end
            WWD_ST_OFF: begin
                tcnt_next = 13'h0000;
                if (!wd_off) begin
                    st_next = WWD_ST_LEAD;
                end
            end
            default: begin
                st_next = WWD_ST_RESET;
            end
        endcase
        // RULE3 bad resistor keeps reset cycling; triggers no longer help
        if (osc_fault && !wd_off && (st_reg inside {WWD_ST_LEAD, WWD_ST_CLOSED, WWD_ST_OPEN})) begin
            st_next = WWD_ST_FAILSAFE;
            tcnt_next = 13'h0000;
        end
        if (wd_off && st_reg != WWD_ST_RESET) begin
            st_next = WWD_ST_OFF;
        end
        // RULE12 undervoltage holds reset and restarts its time
        if (f_s.vcc_uv) begin
            st_next = WWD_ST_RESET;
            cyc_next = 17'h00000;
        end
    end

    // Sequence and bookkeeping registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= WWD_ST_RESET;
            cyc_reg <= 17'h00000;
            tcnt_reg <= 13'h0000;
            div_reg <= 9'h000;
            tlo_reg <= 8'h00;
            osc_d_reg <= 1'b0;
            por_reg <= 1'b1;
            strap_dis_reg <= 1'b0;
            cfg_dis_reg <= 1'b0;
            pend_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            cyc_reg <= cyc_next;
            tcnt_reg <= tcnt_next;
            div_reg <= div_next;
            tlo_reg <= tlo_next;
            osc_d_reg <= osc_s;
            por_reg <= por_next;
            strap_dis_reg <= strap_dis_next;
            cfg_dis_reg <= cfg_dis_next;
            pend_reg <= pend_next;
        end
    end

    logic [15:0] deb_reg, deb_next;
    logic irq_reg, irq_next, lin_off_reg, lin_off_next, short_d_reg, wake_next, wake_reg;
    logic rxd_reg, miso_reg, oe_reg, vcc_reg, dom_reg, ign_done;

    // RULE7 low input is passive and clears the debounce
    assign ign_done = ign_s & (deb_reg == 16'(DEB_CYC - 1));

    // Ignition, LIN and regulator reactions
    always_comb begin
        deb_next = (!ign_s || deb_reg == 16'(DEB_CYC)) ? (ign_s ? deb_reg : 16'h0000)
                                                     : deb_reg + 16'h0001;
        // RULE8 debounced edge lowers the interrupt; a new event beats a clear
        irq_next = (irq_reg & ~irq_clr) | (ign_done & ~sleep_mode);
        // RULE11 short removal during sleep is a remote wake
        wake_next = sleep_mode & ((ign_done) | (short_d_reg & ~f_s.lin_short));
        // RULE9 restart only after cooling and a dominant request
        lin_off_next = f_s.lin_ot | (lin_off_reg & txd_s);
    end

    // Reaction registers and outputs
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            deb_reg <= 16'h0000;
            irq_reg <= 1'b0;
            wake_reg <= 1'b0;
            lin_off_reg <= 1'b0;
            short_d_reg <= 1'b0;
            rxd_reg <= 1'b1;
            miso_reg <= 1'b0;
            oe_reg <= 1'b0;
            vcc_reg <= 1'b0;
            dom_reg <= 1'b0;
        end else begin
            deb_reg <= deb_next;
            irq_reg <= irq_next;
            wake_reg <= wake_next;
            lin_off_reg <= lin_off_next;
            short_d_reg <= f_s.lin_short;
            // RULE10 bus level always reaches the receive output
            rxd_reg <= bus_s;
            miso_reg <= spi_miso_data;
            // RULE14 deselected means tri-state
            oe_reg <= ~sel_n_s;
            // RULE13 only the regulator's own monitor switches it
            vcc_reg <= ~f_s.vcc_ot;
            // RULE15 high transmit stays recessive
            dom_reg <= ~txd_s & ~lin_off_next;
        end
    end

    assign wd_reset_n = (st_reg != WWD_ST_RESET);
    assign irq_out_n = ~irq_reg;
    assign wake_req = wake_reg;
    assign rxd_out = rxd_reg;
    assign spi_miso_out = miso_reg;
    assign spi_miso_oe = oe_reg;
    assign vcc_enable = vcc_reg;
    assign lin_drv_dominant = dom_reg;
    assign wd_state = st_reg;
    assign wd_disabled = wd_off;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    closed_trig_rst_a: assert property (st_reg == WWD_ST_CLOSED && trig_acc |=> !wd_reset_n) // RULE16
        else $error("closed window trigger did not reset");
    open_miss_rst_a: assert property (st_reg == WWD_ST_OPEN && wd_tick && !osc_fault && !wd_off
        && tcnt_reg == 13'(OPEN_TICKS - 1) && !trig_acc |=> !wd_reset_n) // RULE16
        else $error("missed open window did not reset");
    trig_width_a: assert property (trig_acc |-> $past(trig_n_s, TRIG_CYC) == 1'b0) // RULE18
        else $error("short trigger accepted");
    rst_length_a: assert property ($fell(wd_reset_n) && !f_s.vcc_uv ##1 !f_s.vcc_uv [*8]
        |-> !wd_reset_n) // RULE17
        else $error("reset pulse too short");
    uv_reset_a: assert property (f_s.vcc_uv |=> !wd_reset_n) // RULE12
        else $error("undervoltage did not reset");
    wdd_single_a: assert property (cfg_wr && cfg_wd_disable_bit && !pend_reg && !cfg_dis_reg
        |=> !cfg_dis_reg) // RULE6
        else $error("single write disabled watchdog");
    fs_fallback_a: assert property (osc_fault && !wd_off && !f_s.vcc_uv
        && (st_reg inside {WWD_ST_LEAD, WWD_ST_CLOSED, WWD_ST_OPEN})
        |=> st_reg == WWD_ST_FAILSAFE) // RULE4
        else $error("pin fault did not enter fail-safe timing");
    fs_reset_a: assert property (st_reg == WWD_ST_FAILSAFE && wd_tick && ofs_reg[1]
        && tcnt_reg == 13'(FS_SHORT_TICKS - 1) && !wd_off |=> !wd_reset_n) // RULE5
        else $error("fail-safe reset missing");
    lin_reen_a: assert property (lin_off_reg && txd_s |=> lin_off_reg) // RULE9
        else $error("LIN driver re-enabled without dominant");
    rxd_follow_a: assert property (rxd_out == $past(bus_s)) // RULE10
        else $error("receive output not tracking bus");
    vcc_indep_a: assert property (!f_s.vcc_ot |=> vcc_enable) // RULE13
        else $error("regulator off without own fault");
    irq_set_a: assert property (ign_done && !sleep_mode |=> !irq_out_n) // RULE8
        else $error("ignition interrupt missing");
    miso_tri_a: assert property (sel_n_s |=> !spi_miso_oe) // RULE14
        else $error("serial output driven while deselected");
    tx_recessive_a: assert property (txd_s |=> !lin_drv_dominant) // RULE15
        else $error("dominant with transmit high");

    open_ok_c: cover property (st_reg == WWD_ST_OPEN && trig_acc);
    lead_miss_c: cover property (st_reg == WWD_ST_LEAD ##1 st_reg == WWD_ST_RESET);
    failsafe_c: cover property (st_reg == WWD_ST_FAILSAFE ##1 st_reg == WWD_ST_RESET);
    wake_c: cover property (wake_req);
endmodule
`default_nettype wire

// [core/wwd_sync.sv]
// Purpose: Two-flop synchroniser for a group of asynchronous levels
// Assumes: Each bit is an independent level
// Notes: The first stage is read by the second stage only
`timescale 1ns/1ps
`default_nettype none
module wwd_sync #(
    parameter int W = 4,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    import wwd_pkg::*;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_reg;
            logic stab_reg;
            // Two stages per bit; reset to the idle level so no false edge follows
            always_ff @(posedge core_clk or negedge arst_n) begin
                if (!arst_n) begin
                    meta_reg <= RST_VAL[i];
                    stab_reg <= RST_VAL[i];
                end else begin
                    meta_reg <= async_in[i];
                    stab_reg <= meta_reg;
                end
            end
            assign sync_out[i] = stab_reg;
        end
    endgenerate
endmodule
`default_nettype wire

// [verification/tb.sv]
// Purpose: Self-checking bench for the window watchdog supervisor
// Assumes: Shortened counts; oscillator tick every 40 core cycles
// Notes: Tick phase is free, so window times are checked within one tick of slack
`timescale 1ns/1ps
`default_nettype none
module tb;
    import wwd_pkg::*;
    localparam int RST = 200;
    localparam int TP = 40;
    logic core_clk, arst_n, wd_trigger_n, strap, spi_select_n, txd_in, ignition_input;
    logic wd_reset_n, irq_out_n, rxd_out, spi_miso_out, spi_miso_oe, wd_timing_pin;
    logic lin_bus_level, lin_drv_dominant, vcc_enable, cfg_wr, cfg_bit, irq_clr, sleep_mode;
    logic spi_miso_data, wake_req, wd_disabled;
    logic [7:0] rst_seen;
    wwd_fault_t faults;
    wwd_state_t wd_state;
    int error_cnt = 0;
    int n_checks = 0;
    int wake_cnt = 0;
    int w0, r0;

    wwd_supervisor #(.RST_CYC(RST), .LEAD_TICKS(20), .CLOSED_TICKS(5), .OPEN_TICKS(6),
        .FS_SHORT_TICKS(4), .FS_OPEN_TICKS(7), .INT_OSC_DIV(8), .DEB_CYC(10)) uut (
        .core_clk(core_clk), .arst_n(arst_n), .wd_trigger_n(wd_trigger_n),
        .divider_strap_pin(strap), .spi_select_n(spi_select_n), .txd_in(txd_in),
        .ignition_input(ignition_input), .wd_reset_n(wd_reset_n), .irq_out_n(irq_out_n),
        .rxd_out(rxd_out), .spi_miso_out(spi_miso_out), .spi_miso_oe(spi_miso_oe),
        .wd_timing_pin(wd_timing_pin), .faults(faults), .lin_bus_level(lin_bus_level),
        .lin_drv_dominant(lin_drv_dominant), .vcc_enable(vcc_enable), .cfg_wr(cfg_wr),
        .cfg_wd_disable_bit(cfg_bit), .irq_clr(irq_clr), .sleep_mode(sleep_mode),
        .spi_miso_data(spi_miso_data), .wake_req(wake_req), .wd_state(wd_state),
        .wd_disabled(wd_disabled));

    wwd_host_model host (.core_clk(core_clk), .wd_reset_n(wd_reset_n),
        .wd_trigger_n(wd_trigger_n), .rst_seen(rst_seen));

    // Clock and free-running oscillator pin
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        wd_timing_pin = 1'b0;
        forever begin
            repeat (TP / 2) @(posedge core_clk);
            #1 wd_timing_pin = ~wd_timing_pin;
        end
    end

    // Wake pulses are one cycle wide, so they are tallied at every edge
    always @(posedge core_clk) begin
        if (wake_req === 1'b1) begin
            wake_cnt <= wake_cnt + 1;
        end
    end

    task automatic report_and_stop();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %s expected %0h seen %0h", name, e, g);
        end
    endtask

    // Bounded wait for a state; too early or too late is a mismatch
    task automatic wait_st(input wwd_state_t e, input int lo, input int hi);
        int n;
        n = 0;
        while (wd_state !== e && n <= hi) begin
            step(1);
            n++;
        end
        n_checks++;
        if (n < lo || n > hi) begin
            error_cnt++;
            $display("FAIL wd_state expected %0h seen %0h after %0d", e, wd_state, n);
            if (n > hi) report_and_stop();
        end
    endtask

    task automatic cfg(input logic b);
        cfg_wr = 1'b1;
        cfg_bit = b;
        step(1);
        cfg_wr = 1'b0;
        step(1);
    endtask

    task automatic t_reset_and_lead();
        chk("reset_n in reset", 1'b0, wd_reset_n);
        chk("irq in reset", 1'b1, irq_out_n);
        chk("state in reset", WWD_ST_RESET, wd_state);
        arst_n = 1'b1;
        wait_st(WWD_ST_LEAD, RST - 5, RST + 5);
        chk("reset_n released", 1'b1, wd_reset_n);
        wait_st(WWD_ST_RESET, 20 * TP - TP, 20 * TP + 2 * TP);
        chk("reset_n lead miss", 1'b0, wd_reset_n);
        wait_st(WWD_ST_LEAD, RST - 5, RST + 5);
    endtask

    task automatic t_windows();
        host.trig(100);
        chk("short pulse ignored", WWD_ST_LEAD, wd_state);
        host.trig(150);
        chk("lead trigger", WWD_ST_CLOSED, wd_state);
        wait_st(WWD_ST_OPEN, 5 * TP - TP - 10, 5 * TP + TP);
        host.trig(150);
        chk("open trigger restarts", WWD_ST_CLOSED, wd_state);
        wait_st(WWD_ST_OPEN, 5 * TP - TP - 10, 5 * TP + TP);
        wait_st(WWD_ST_RESET, 6 * TP - TP, 6 * TP + TP);
        chk("reset_n open miss", 1'b0, wd_reset_n);
        wait_st(WWD_ST_LEAD, RST - 5, RST + 5);
        host.trig(145);
        host.trig(145);
        chk("closed trigger", WWD_ST_RESET, wd_state);
        chk("reset_n closed trig", 1'b0, wd_reset_n);
        wait_st(WWD_ST_LEAD, RST - 160, RST + 5);
    endtask

    task automatic t_disable();
        cfg(1'b1);
        cfg(1'b0);
        cfg(1'b1);
        chk("single write", 1'b0, wd_disabled);
        chk("single write state", WWD_ST_LEAD, wd_state);
        cfg(1'b1);
        step(1);
        chk("double write", 1'b1, wd_disabled);
        chk("double write state", WWD_ST_OFF, wd_state);
        faults.osc_short = 1'b1;
        step(20);
        chk("fault while off", WWD_ST_OFF, wd_state);
        faults.osc_short = 1'b0;
        step(5);
        cfg(1'b0);
        step(1);
        chk("re-enable", WWD_ST_LEAD, wd_state);
    endtask

    task automatic t_failsafe();
        faults.osc_short = 1'b1;
        wait_st(WWD_ST_FAILSAFE, 0, 10);
        wait_st(WWD_ST_RESET, 3 * 8, 4 * 8 + 16);
        step(1);
        r0 = rst_seen;
        wait_st(WWD_ST_FAILSAFE, RST - 5, RST + 15);
        wait_st(WWD_ST_RESET, 3 * 8, 4 * 8 + 16);
        step(2);
        chk("repeated resets", r0 + 1, rst_seen);
        faults.osc_short = 1'b0;
        faults.osc_open = 1'b1;
        wait_st(WWD_ST_FAILSAFE, RST - 5, RST + 15);
        wait_st(WWD_ST_RESET, 6 * 8, 7 * 8 + 16);
        faults.osc_open = 1'b0;
        wait_st(WWD_ST_LEAD, RST - 5, RST + 5);
    endtask

    task automatic t_ignition();
        chk("irq idle", 1'b1, irq_out_n);
        ignition_input = 1'b1;
        step(8);
        chk("irq debouncing", 1'b1, irq_out_n);
        step(8);
        chk("irq after debounce", 1'b0, irq_out_n);
        irq_clr = 1'b1;
        step(1);
        irq_clr = 1'b0;
        step(3);
        chk("irq cleared", 1'b1, irq_out_n);
        ignition_input = 1'b0;
        sleep_mode = 1'b1;
        step(4);
        chk("sleep state", WWD_ST_OFF, wd_state);
        w0 = wake_cnt;
        ignition_input = 1'b1;
        step(20);
        chk("ignition wake", w0 + 1, wake_cnt);
        chk("no irq asleep", 1'b1, irq_out_n);
        ignition_input = 1'b0;
        faults.lin_short = 1'b1;
        step(10);
        chk("sleep with lin short", w0 + 1, wake_cnt);
        faults.lin_short = 1'b0;
        step(10);
        chk("remote wake", w0 + 2, wake_cnt);
        sleep_mode = 1'b0;
        step(2);
    endtask

    task automatic t_lin_vcc_spi();
        txd_in = 1'b0;
        step(5);
        chk("dominant drive", 1'b1, lin_drv_dominant);
        faults.lin_ot = 1'b1;
        lin_bus_level = 1'b0;
        step(5);
        chk("lin thermal off", 1'b0, lin_drv_dominant);
        chk("rxd low in shutdown", 1'b0, rxd_out);
        chk("vcc unaffected", 1'b1, vcc_enable);
        lin_bus_level = 1'b1;
        txd_in = 1'b1;
        step(5);
        chk("rxd high in shutdown", 1'b1, rxd_out);
        faults.lin_ot = 1'b0;
        step(5);
        txd_in = 1'b0;
        step(5);
        chk("restart on dominant", 1'b1, lin_drv_dominant);
        txd_in = 1'b1;
        step(5);
        chk("recessive on high", 1'b0, lin_drv_dominant);
        faults.vcc_ot = 1'b1;
        step(5);
        chk("vcc thermal off", 1'b0, vcc_enable);
        faults.vcc_ot = 1'b0;
        step(5);
        chk("vcc back on", 1'b1, vcc_enable);
        faults.vcc_uv = 1'b1;
        step(6);
        chk("undervoltage reset", 1'b0, wd_reset_n);
        faults.vcc_uv = 1'b0;
        chk("miso off deselected", 1'b0, spi_miso_oe);
        spi_select_n = 1'b0;
        spi_miso_data = 1'b1;
        step(5);
        chk("miso on selected", 1'b1, spi_miso_oe);
        chk("miso data", 1'b1, spi_miso_out);
        spi_select_n = 1'b1;
        step(5);
        chk("miso off again", 1'b0, spi_miso_oe);
    endtask

    // Mid-run reset with the strap high: watchdog off from the start, timing pin short ignored
    task automatic t_strap();
        strap = 1'b1;
        arst_n = 1'b0;
        step(3);
        chk("reset_n in second reset", 1'b0, wd_reset_n);
        arst_n = 1'b1;
        wait_st(WWD_ST_LEAD, RST - 5, RST + 5);
        step(2);
        chk("strap disables", 1'b1, wd_disabled);
        chk("strap state", WWD_ST_OFF, wd_state);
        faults.osc_short = 1'b1;
        step(20);
        chk("strap off with fault", WWD_ST_OFF, wd_state);
        faults.osc_short = 1'b0;
    endtask

    // Main sequence, and a limit on the whole run
    initial begin
        arst_n = 1'b0;
        strap = 1'b0;
        spi_select_n = 1'b1;
        txd_in = 1'b1;
        ignition_input = 1'b0;
        lin_bus_level = 1'b1;
        faults = '0;
        cfg_wr = 1'b0;
        cfg_bit = 1'b0;
        irq_clr = 1'b0;
        sleep_mode = 1'b0;
        spi_miso_data = 1'b0;
        step(3);
        t_reset_and_lead();
        t_windows();
        t_disable();
        t_failsafe();
        t_ignition();
        t_lin_vcc_spi();
        t_strap();
        report_and_stop();
    end
    initial begin
        #(100000 * 50);
        error_cnt++;
        report_and_stop();
    end
endmodule
`default_nettype wire

// [verification/wwd_host_model.sv]
// Purpose: Host controller model that pulses the watchdog trigger and watches reset
// Assumes: Driven from the bench by task call; pin changes 1 ns after the clock edge
// Notes: Counts every falling edge of the reset output it receives
`timescale 1ns/1ps
`default_nettype none
module wwd_host_model (
    // Clock
    input wire logic core_clk,
    // Reset seen from the supervisor
    input wire logic wd_reset_n,
    // Trigger pin and reset tally
    output logic wd_trigger_n,
    output logic [7:0] rst_seen
);
    logic rst_prev;

    // Idle trigger level is high, reset tally starts at zero
    initial begin
        wd_trigger_n = 1'b1;
        rst_seen = 8'h00;
        rst_prev = 1'b0;
    end

    // first pulse in lead
    // Pulse low for a given number of cycles, then release high
    task automatic trig(input int low_cyc);
        @(posedge core_clk);
        #1 wd_trigger_n = 1'b0;
        repeat (low_cyc) @(posedge core_clk);
        #1 wd_trigger_n = 1'b1;
    endtask

    // Tally reset assertions, so repeated fail-safe resets can be counted
    always @(posedge core_clk) begin
        if (rst_prev === 1'b1 && wd_reset_n === 1'b0) begin
            rst_seen <= rst_seen + 8'h01;
        end
        rst_prev <= wd_reset_n;
    end
endmodule
`default_nettype wire
